// file: hw/slsd_driver.sv
// Serial-in shift register, transparent latches and blanked sink outputs.
`timescale 1ns/1ps
module slsd_driver
   import slsd_pkg::*;
(
   input  wire logic                        core_clk,
   input  wire logic                        rst_n,
   input  wire logic                        serialClk,
   input  wire logic                        serialIn,
   input  wire logic                        latchStrobe,
   input  wire logic                        outEnableN,
   input  wire logic                        shiftHold,
   output logic [slsd_pkg::STAGES-1:0]      sink_outputs,
   output logic                             serialOut,
   output logic                             bitReady,
   output logic                             bitOverrun,
   output logic                             gapViolation,
   output logic                             blankShort,
   output logic                             bypassShiftWarn
);
   import slsd_pkg::*;

   // Datapath overview:
   //  - the clock, data, strobe and enable pins pass two flops; a third flop marks clock, strobe and enable edges
   //  - a serial clock rise pushes the synchronised data bit into the
   //    bit FIFO, which the register drains one bit per core cycle
   //  - the FIFO decouples pin timing from shiftHold back-pressure; a
   //    bit that arrives while it is full is lost and flagged
   //  - the latch copies the register's next value while the strobe is
   //    high, so an open latch never lags the register by a cycle
   //  - blanking gates only the sink outputs, never the latch contents
   //  - timing monitors watch the controller and never alter behaviour
   // Limitation: each synchronised pin lags by two core cycles, so pin pulses
   // shorter than one core cycle may be missed altogether.

   // Rising edge of a synchronised level, used for several pins
   function automatic logic rise(input logic prev, input logic cur);
      rise = cur && !prev;
   endfunction

   // Saturating cycle counter step
   function automatic logic [7:0] bump(input logic [7:0] cnt);
      bump = (cnt == COUNT_IDLE) ? cnt : cnt + 8'h01;
   endfunction

   // Least-time test shared by the strobe gap and blank pulse monitors
   function automatic logic tooShort(input logic [7:0] cnt,
                                     input logic [7:0] least);
      tooShort = cnt < least;
   endfunction

   // Pin synchronisers, first stage read only by the second
   logic clkMeta_q;
   logic clkSync_q;
   logic clkPrev_q;
   logic dataMeta_q;
   logic dataSync_q;
   logic strobeMeta_q;
   logic strobeSync_q;
   logic strobePrev_q;
   logic oeMeta_q;
   logic oeSync_q;
   logic oePrev_q;

   // Datapath state
   logic [STAGES-1:0] shift_q;
   logic [STAGES-1:0] shift_d;
   logic [STAGES-1:0] latch_q;
   logic [STAGES-1:0] latch_d;
   logic              serialOut_q;

   // FIFO handshake
   logic                  clkEdge;
   logic                  fifoInReady;
   logic                  fifoOutValid;
   logic [FIFO_WIDTH-1:0] fifoOutData;
   logic                  popBit;

   // Timing monitors
   logic [7:0] gapCnt_q;
   logic [7:0] gapCnt_d;
   logic [7:0] blankCnt_q;
   logic [7:0] blankCnt_d;
   logic       strobeRise;
   logic       oeRise;
   logic       oeFall;
   logic       overrun_q;
   logic       gapViol_q;
   logic       blankShort_q;
   logic       bypassWarn_q;

   // Serial clock pin synchroniser; idles low like a stopped clock
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clkMeta_q <= 1'b0;
         clkSync_q <= 1'b0;
      end else begin
         clkMeta_q <= serialClk;
         clkSync_q <= clkMeta_q;
      end
   end

   // Serial data synchroniser, same depth as the clock path
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dataMeta_q <= 1'b0;
         dataSync_q <= 1'b0;
      end else begin
         dataMeta_q <= serialIn;
         dataSync_q <= dataMeta_q;
      end
   end

   // Latch strobe synchroniser; idles low like its pull-down
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         strobeMeta_q <= 1'b0;
         strobeSync_q <= 1'b0;
      end else begin
         strobeMeta_q <= latchStrobe;
         strobeSync_q <= strobeMeta_q;
      end
   end

   // Output enable synchroniser; resets high so sinks start dark
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         oeMeta_q <= 1'b1;
         oeSync_q <= 1'b1;
      end else begin
         oeMeta_q <= outEnableN;
         oeSync_q <= oeMeta_q;
      end
   end

   // Previous serial clock level for the rise detector
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clkPrev_q <= 1'b0;
      end else begin
         clkPrev_q <= clkSync_q;
      end
   end

   // Previous strobe level, idle low as the pin
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         strobePrev_q <= 1'b0;
      end else begin
         strobePrev_q <= strobeSync_q;
      end
   end

   // Previous enable level; matches its reset so no false edge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         oePrev_q <= 1'b1;
      end else begin
         oePrev_q <= oeSync_q;
      end
   end

   // Edge decode; data travels through the same depth so stays aligned
   assign clkEdge    = rise(clkPrev_q, clkSync_q);
   assign strobeRise = rise(strobePrev_q, strobeSync_q);
   assign oeRise     = rise(oePrev_q, oeSync_q);
   assign oeFall     = rise(oeSync_q, oePrev_q);

   // Captured bits queue here so a stalled register drops none until the FIFO is full
   slsd_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) slsd_fifo_i (
      .clk      (core_clk),
      .rst_n    (rst_n),
      .inValid  (clkEdge),
      .inReady  (fifoInReady),
      .inData   (dataSync_q),
      .outValid (fifoOutValid),
      .outReady (!shiftHold),
      .outData  (fifoOutData)
   );

   assign popBit   = fifoOutValid && !shiftHold;
   assign bitReady = fifoInReady;

   // Serial input enters stage zero, every stage moves up one
   assign shift_d = popBit ? {shift_q[STAGES-2:0], fifoOutData[0]}
                           : shift_q;

   // Transparent latch follows the next register value, so the
   // latches track a shift in the very cycle it happens
   assign latch_d = strobeSync_q ? shift_d : latch_q;

   // Shift register state
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_q <= SHIFT_RESET;
      end else begin
         shift_q <= shift_d;
      end
   end

   // Latch state; the enable never reaches this path
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_q <= LATCH_RESET;
      end else begin
         latch_q <= latch_d;
      end
   end

   // Registered copy of the last stage, moving with the register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         serialOut_q <= 1'b0;
      end else begin
         serialOut_q <= shift_d[STAGES-1];
      end
   end

   assign serialOut = serialOut_q;

   // One gated sink per latch bit, no clock in the path
   genvar gi;
   generate
      for (gi = 0; gi < STAGES; gi++) begin : g_sink
         // Blanking masks the output only, never the latch
         assign sink_outputs[gi] = latch_q[gi] && !oeSync_q;
      end
   endgenerate

   // Cycles since the last serial clock edge, saturating; counting
   // from one lets a strobe exactly the least gap after an edge pass
   assign gapCnt_d = clkEdge ? 8'h01 : bump(gapCnt_q);

   // Length of the current output enable high pulse
   assign blankCnt_d = oeRise   ? 8'h01 :
                       oeSync_q ? bump(blankCnt_q) : blankCnt_q;

   // Gap counter starts saturated, so no false flag after reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gapCnt_q <= COUNT_IDLE;
      end else begin
         gapCnt_q <= gapCnt_d;
      end
   end

   // Blank pulse counter, also starting saturated
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         blankCnt_q <= COUNT_IDLE;
      end else begin
         blankCnt_q <= blankCnt_d;
      end
   end

   // Bit lost: serial clock edge while the FIFO was full
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         overrun_q <= 1'b0;
      end else begin
         overrun_q <= clkEdge && !fifoInReady;
      end
   end

   // Strobe raised with, or too soon after, a serial clock edge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gapViol_q <= 1'b0;
      end else begin
         gapViol_q <= strobeRise
                      && (clkEdge || tooShort(gapCnt_q, GAP_CYCLES));
      end
   end

   // Enable high pulse ended before its least width
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         blankShort_q <= 1'b0;
      end else begin
         blankShort_q <= oeFall
                         && tooShort(blankCnt_q, BLANK_CYCLES);
      end
   end

   // Shift while latches are open and the sinks are lit
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bypassWarn_q <= 1'b0;
      end else begin
         bypassWarn_q <= clkEdge && strobeSync_q && !oeSync_q;
      end
   end

   assign bitOverrun      = overrun_q;
   assign gapViolation    = gapViol_q;
   assign blankShort      = blankShort_q;
   assign bypassShiftWarn = bypassWarn_q;

endmodule

// file: hw/slsd_fifo.sv
// Parameterised FIFO holding sampled serial bits ahead of the register.
`timescale 1ns/1ps
module slsd_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_q;
   logic [AW:0]      rdPtr_q;
   logic             pushEn;
   logic             popEn;
   logic             ptrMsbDiff;
   logic             ptrLowSame;

   // Extra pointer bit tells full from empty
   assign ptrMsbDiff = wrPtr_q[AW] != rdPtr_q[AW];
   assign ptrLowSame = wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0];
   assign inReady    = !(ptrMsbDiff && ptrLowSame);
   assign outValid   = !(!ptrMsbDiff && ptrLowSame);
   assign pushEn     = inValid && inReady;
   assign popEn      = outValid && outReady;
   assign outData    = mem[rdPtr_q[AW-1:0]];

   // Storage needs no reset; only entries behind the pointers are read
   always_ff @(posedge clk) begin
      if (pushEn) begin
         mem[wrPtr_q[AW-1:0]] <= inData;
      end
   end

   // Pointer update
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         if (pushEn) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (popEn) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
      end
   end

endmodule

// file: hw/slsd_pkg.sv
// Constants shared by the serial latched sink driver and its bit FIFO.
// Summary of operation
// - Each rising edge of the serial clock shifts the register by one place, taking in the serial input level; an edge that finds the bit FIFO full is lost.
// - The serial input enters the first of the eight register stages.
// - The last register stage drives the serial output for the next device in a chain.
// - While the latch strobe is high each latch copies its register stage.
// - The latches follow every new register value while the strobe is high and hold once it drops.
// - Output enable high turns all eight sink outputs off whatever the latches hold.
// - Output enable never alters the latch contents.
// - With output enable low each sink output follows its own latch bit.
// - There are eight sink outputs, numbered zero to seven, one per latch bit.
package slsd_pkg;

   // Structure
   localparam int STAGES      = 8;
   localparam int FIFO_DEPTH  = 32;
   localparam int FIFO_WIDTH  = 1;

   // Reset values
   localparam logic [STAGES-1:0] SHIFT_RESET = 8'h00;
   localparam logic [STAGES-1:0] LATCH_RESET = 8'h00;
   localparam logic [7:0]        COUNT_IDLE  = 8'hff;

   // Timing, in the core clock
   localparam int CLK_PERIOD_NS           = 25;
   localparam int SHIFT_TO_STROBE_GAP_NS  = 100;
   localparam int BLANK_PULSE_NS          = 4500;
   // Least times round up to whole cycles
   localparam logic [7:0] GAP_CYCLES =
      8'((SHIFT_TO_STROBE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] BLANK_CYCLES =
      8'((BLANK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// file: sim/slsd_controller_model.sv
// Behavioural controller model driving the driver's pins.
`timescale 1ns/1ps
module slsd_controller_model (
   input  wire logic core_clk,
   output logic      serialClk,
   output logic      serialIn,
   output logic      latchStrobe,
   output logic      outEnableN
);
   // Idle: enable pulled up, strobe pulled down, clock stopped
   initial begin
      serialClk = 1'b0;
      serialIn = 1'b0;
      latchStrobe = 1'b0;
      outEnableN = 1'b1;
   end
   // Three-cycle phases; data flips once its hold has run out
   task automatic sendBit(input logic b);
      @(negedge core_clk) serialIn = b;
      repeat (3) @(negedge core_clk);
      serialClk = 1'b1;
      repeat (3) @(negedge core_clk);
      serialClk = 1'b0;
      serialIn = ~b;
      repeat (3) @(negedge core_clk);
   endtask
   // Top bit first, so it ends in the last stage
   task automatic sendByte(input logic [7:0] d);
      for (int i = 7; i >= 0; i--) sendBit(d[i]);
   endtask
   // Strobe raised one cycle after the clock, too soon on purpose
   task automatic rushStrobe(input logic b);
      @(negedge core_clk) serialIn = b;
      repeat (3) @(negedge core_clk);
      serialClk = 1'b1;
      @(negedge core_clk) latchStrobe = 1'b1;
      repeat (2) @(negedge core_clk);
      serialClk = 1'b0;
      serialIn = ~b;
      repeat (5) @(negedge core_clk);
   endtask
   // Levels settle past the synchronisers before returning
   task automatic setPins(input logic s, input logic e);
      @(negedge core_clk) latchStrobe = s;
      outEnableN = e;
      repeat (5) @(negedge core_clk);
   endtask
endmodule

// file: sim/slsd_driver_checker.sv
// Port assertions for the serial latched sink driver.
`timescale 1ns/1ps
module slsd_driver_checker
   import slsd_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       latchStrobe,
   input wire logic       outEnableN,
   input wire logic       shiftHold,
   input wire logic [7:0] sink_outputs,
   input wire logic       serialOut,
   input wire logic       bitReady,
   input wire logic       bitOverrun
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // Four samples outlast the two-flop pin synchronisers
   sequence shown(logic open);
      (!outEnableN && latchStrobe == open)[*4];
   endsequence
   // Blanking bites exactly two samples after the pin rises
   sequence darkAfterTwo;
      ##1 $stable(sink_outputs) ##1 !(|sink_outputs);
   endsequence

   AST_DARK: assert property (outEnableN[*3] |-> !(|sink_outputs))
      else $error("sinks on while blanked");
   AST_HOLD: assert property (shown(1'b0) |-> $stable(sink_outputs))
      else $error("sinks moved with strobe low");
   AST_OPEN:
      assert property (shown(1'b1) |-> sink_outputs[7] == serialOut)
      else $error("open latch not following last stage");
   AST_LIT:
      assert property (|sink_outputs |-> !$past(outEnableN, 2))
      else $error("sink on without enable");
   AST_EDGE:
      assert property ($rose(outEnableN) && !latchStrobe |-> darkAfterTwo)
      else $error("blanking not two cycles after pin");
   AST_STALL: assert property (shiftHold[*3] |-> $stable(serialOut))
      else $error("shift while stalled");
   AST_FULL:
      assert property (bitOverrun |-> !$past(bitReady) || !$past(bitReady, 2))
      else $error("overrun with room left");
   AST_ONCE: assert property (bitOverrun |=> !bitOverrun)
      else $error("overrun pulse too long");
endmodule

bind slsd_driver slsd_driver_checker slsd_driver_checker_i (.core_clk,
   .rst_n, .latchStrobe, .outEnableN, .shiftHold, .sink_outputs,
   .serialOut, .bitReady, .bitOverrun);

// file: sim/slsd_driver_test.sv
// Self-checking bench for the serial latched sink driver.
`timescale 1ns/1ps
module slsd_driver_test;
   import slsd_pkg::*;
   logic       core_clk, rst_n, shiftHold, serialOut, bitReady;
   logic       serialClk, serialIn, latchStrobe, outEnableN;
   logic       bitOverrun, gapViolation, blankShort, bypassShiftWarn;
   logic       sawOverrun;
   logic [2:0] sawFlags;
   logic [7:0] sink_outputs;
   int         bad_count, checked, cycles;

   slsd_driver slsd_driver_i (.core_clk, .rst_n, .serialClk, .serialIn,
      .latchStrobe, .outEnableN, .shiftHold, .sink_outputs, .serialOut,
      .bitReady, .bitOverrun, .gapViolation, .blankShort, .bypassShiftWarn);
   slsd_controller_model slsd_controller_model_i (.core_clk, .serialClk,
      .serialIn, .latchStrobe, .outEnableN);

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Pulses caught sticky where settled; ceiling about four times the run
   always @(negedge core_clk) begin
      cycles++;
      if (bitOverrun === 1'b1) sawOverrun = 1'b1;
      sawFlags = sawFlags | {bypassShiftWarn, blankShort, gapViolation};
      if (cycles == 5000) begin
         bad_count++;
         report_and_stop();
      end
   end

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic strobe();
      slsd_controller_model_i.setPins(1'b1, 1'b0);
      slsd_controller_model_i.setPins(1'b0, 1'b0);
   endtask
   // One byte through, then one extra bit behind it
   task automatic testLoad();
      slsd_controller_model_i.sendByte(8'ha5);
      chk("held sinks", 8'h00, sink_outputs);
      strobe();
      chk("loaded sinks", 8'ha5, sink_outputs);
      chk("serial out", 8'h01, 8'(serialOut));
      slsd_controller_model_i.sendBit(1'b1);
      chk("serial out next", 8'h00, 8'(serialOut));
      strobe();
      chk("first stage", 8'h4b, sink_outputs);
      $display("testLoad done");
   endtask
   // Blank for a full pulse while the register changes beneath
   task automatic testBlank();
      slsd_controller_model_i.setPins(1'b0, 1'b1);
      repeat (180) @(negedge core_clk);
      chk("blanked", 8'h00, sink_outputs);
      slsd_controller_model_i.sendByte(8'h00);
      slsd_controller_model_i.setPins(1'b0, 1'b0);
      chk("relit", 8'h4b, sink_outputs);
      $display("testBlank done");
   endtask
   // Open latch shifting is done dark, as bypass use demands
   task automatic testOpen();
      slsd_controller_model_i.setPins(1'b1, 1'b1);
      slsd_controller_model_i.sendByte(8'h81);
      slsd_controller_model_i.setPins(1'b0, 1'b1);
      slsd_controller_model_i.sendByte(8'h3c);
      repeat (40) @(negedge core_clk);
      slsd_controller_model_i.setPins(1'b0, 1'b0);
      chk("open latch kept", 8'h81, sink_outputs);
      $display("testOpen done");
   endtask
   // Stall the drain, overfill by one bit, then drain
   task automatic testFifo();
      @(negedge core_clk) shiftHold = 1'b1;
      for (int i = 1; i <= 4; i++)
         slsd_controller_model_i.sendByte(8'(i * 8'h11));
      slsd_controller_model_i.sendBit(1'b1);
      chk("ready full", 8'h00, 8'(bitReady));
      chk("overrun", 8'h01, 8'(sawOverrun));
      @(negedge core_clk) shiftHold = 1'b0;
      repeat (40) @(negedge core_clk);
      chk("ready drained", 8'h01, 8'(bitReady));
      strobe();
      chk("kept bits", 8'h44, sink_outputs);
      chk("monitor flags", 8'h00, 8'(sawFlags));
      $display("testFifo done");
   endtask
   // Break each controller timing rule once and watch its flag
   task automatic testMonitors();
      sawFlags = 3'b000;
      slsd_controller_model_i.setPins(1'b1, 1'b0);
      slsd_controller_model_i.sendBit(1'b1);
      chk("open latch lit", 8'h89, sink_outputs);
      chk("bypass flag", 8'h04, 8'(sawFlags));
      slsd_controller_model_i.setPins(1'b0, 1'b0);
      sawFlags = 3'b000;
      slsd_controller_model_i.rushStrobe(1'b0);
      slsd_controller_model_i.setPins(1'b0, 1'b0);
      chk("rushed load", 8'h12, sink_outputs);
      chk("gap flag", 8'h01, 8'(sawFlags));
      sawFlags = 3'b000;
      slsd_controller_model_i.setPins(1'b0, 1'b1);
      slsd_controller_model_i.setPins(1'b0, 1'b0);
      chk("short blank kept", 8'h12, sink_outputs);
      chk("blank flag", 8'h02, 8'(sawFlags));
      $display("testMonitors done");
   endtask
   // Reset in mid-run clears the pattern, then a byte loads again
   task automatic testReset();
      sawFlags = 3'b000;
      @(negedge core_clk) rst_n = 1'b0;
      @(negedge core_clk);
      chk("reset dark", 8'h00, sink_outputs);
      chk("reset serial out", 8'h00, 8'(serialOut));
      chk("reset room", 8'h01, 8'(bitReady));
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      chk("restart dark", 8'h00, sink_outputs);
      chk("restart flags", 8'h00, 8'(sawFlags));
      slsd_controller_model_i.sendByte(8'h5a);
      strobe();
      chk("restart load", 8'h5a, sink_outputs);
      chk("restart serial out", 8'h00, 8'(serialOut));
      $display("testReset done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      rst_n = 1'b0;
      shiftHold = 1'b0;
      sawOverrun = 1'b0;
      sawFlags = 3'b000;
      repeat (5) @(negedge core_clk);
      rst_n = 1'b1;
      chk("reset sinks", 8'h00, sink_outputs);
      chk("reset ready", 8'h01, 8'(bitReady));
      slsd_controller_model_i.setPins(1'b0, 1'b0);
      testLoad();
      testBlank();
      testOpen();
      testFifo();
      testMonitors();
      testReset();
      report_and_stop();
   end
endmodule
